/* File: verilog/can_irq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_cfg.svh"

module can_irq_ctrl #(
    parameter int RX_CNT_W = 5
) (
    input wire logic I_CLK,                     // core clock
    input wire logic I_RESETN,                  // async reset, active low
    input wire logic [6:0] I_AWADDR,            // write address
    input wire logic I_AWVALID,                 // write address valid
    output logic O_AWREADY,                     // write address ready
    input wire logic [31:0] I_WDATA,            // write data
    input wire logic [3:0] I_WSTRB,             // write byte strobes
    input wire logic I_WVALID,                  // write data valid
    output logic O_WREADY,                      // write data ready
    output logic [1:0] O_BRESP,                 // write response
    output logic O_BVALID,                      // write response valid
    input wire logic I_BREADY,                  // write response ready
    input wire logic [6:0] I_ARADDR,            // read address
    input wire logic I_ARVALID,                 // read address valid
    output logic O_ARREADY,                     // read address ready
    output logic [31:0] O_RDATA,                // read data
    output logic [1:0] O_RRESP,                 // read response
    output logic O_RVALID,                      // read data valid
    input wire logic I_RREADY,                  // read data ready
    input wire logic I_BUS_ERROR,               // bus error pulse
    input wire logic I_ARB_LOST,                // arbitration lost pulse
    input wire logic I_BUS_ACTIVITY,            // bus activity pulse
    input wire logic I_SLEEPING,                // controller asleep
    input wire logic I_ERROR_PASSIVE,           // error passive state
    input wire logic I_BUS_OFF,                 // bus status level
    input wire logic I_TX_BUF_FREE,             // transmit buffer released
    input wire logic I_DATA_OVERRUN,            // overrun status level
    input wire logic [RX_CNT_W-1:0] I_RX_COUNT, // messages in receive fifo
    input wire logic [7:0] I_TX_ERR_CNT,        // transmit error counter
    input wire logic [7:0] I_RX_ERR_CNT,        // receive error counter
    output logic O_IRQ,                         // interrupt request, high
    output logic O_RESET_MODE,                  // reset mode, aborts frames
    output logic O_SLEEP_REQ,                   // sleep mode request
    output logic O_RELEASE_RX,                  // release receive buffer pulse
    output logic O_CLEAR_OVERRUN,               // clear overrun pulse
    output can_irq_pkg::byte_t O_WARN_LIMIT,    // active warning limit
    output logic O_ERROR_STATUS                 // error status level
);
    import can_irq_pkg::*;

    ctrl_state_s s_r;
    ctrl_state_s s_nxt;
    logic [`EV_WIDTH-1:0] ev_level;
    logic [`EV_WIDTH-1:0] ev_rise;
    logic [`EV_WIDTH-1:0] ev_fall;
    logic err_status;
    logic [7:0] set_vec;
    logic [7:0] status_byte;
    logic wr_fire;
    logic wr_en;
    logic rd_take;
    logic flags_read;
    logic release_now;
    logic rx_nonempty;
    logic rx_last;

    ////////////////////////////////////////////////////////////////////////

    function automatic logic is_mapped(input logic [4:0] idx);
        is_mapped = (idx == `IDX_CONFIG) || (idx == `IDX_COMMAND) || (idx == `IDX_STATUS) ||
                    (idx == `IDX_FLAGS) || (idx == `IDX_ENABLE) || (idx == `IDX_WARN);
    endfunction : is_mapped

    function automatic logic [7:0] rd_value(input ctrl_state_s st, input logic [4:0] idx,
                                            input logic [7:0] status);
        if (idx == `IDX_CONFIG)
            rd_value = st.config_byte;
        else if (idx == `IDX_STATUS)
            rd_value = status;
        else if (idx == `IDX_FLAGS)
            rd_value = st.flags;
        else if (idx == `IDX_ENABLE)
            rd_value = st.enable;
        else if (idx == `IDX_WARN)
            rd_value = st.warn_limit;
        else
            rd_value = 8'h00;
    endfunction : rd_value

    ////////////////////////////////////////////////////////////////////////
    // event sources

    assign ev_level[`EV_OVR] = I_DATA_OVERRUN;
    assign ev_level[`EV_TXBUF] = I_TX_BUF_FREE;
    assign ev_level[`EV_OVER127] = (I_TX_ERR_CNT > `PASSIVE_LEVEL) || (I_RX_ERR_CNT > `PASSIVE_LEVEL);
    assign ev_level[`EV_PASSIVE] = I_ERROR_PASSIVE;
    assign ev_level[`EV_BUS] = I_BUS_OFF;
    assign ev_level[`EV_ERR] = err_status;

    can_edge_track #(
        .W(`EV_WIDTH)
    ) u_edges (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_level(ev_level),
        .o_rise(ev_rise),
        .o_fall(ev_fall)
    );

    can_warn_check #(
        .CW(8)
    ) u_warn (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_tx_cnt(I_TX_ERR_CNT),
        .i_rx_cnt(I_RX_ERR_CNT),
        .i_limit(s_r.active_limit),
        .o_err_status(err_status)
    );

    assign rx_nonempty = (I_RX_COUNT != '0);
    assign rx_last = (I_RX_COUNT <= RX_CNT_W'(1));

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`STS_BUS] = I_BUS_OFF;
        status_byte[`STS_ERR] = err_status;
        status_byte[`STS_TXBUF] = I_TX_BUF_FREE;
        status_byte[`STS_OVR] = I_DATA_OVERRUN;
        status_byte[`STS_RXBUF] = rx_nonempty;
    end

    // each event gated by its enable bit
    always_comb
    begin
        set_vec = 8'h00;
        set_vec[`BIT_BUS_ERR] = s_r.enable[`BIT_BUS_ERR] & I_BUS_ERROR;
        set_vec[`BIT_ARB_LOST] = s_r.enable[`BIT_ARB_LOST] & I_ARB_LOST;
        set_vec[`BIT_PASSIVE] = s_r.enable[`BIT_PASSIVE] &
                                (ev_fall[`EV_PASSIVE] | ev_rise[`EV_OVER127]);
        set_vec[`BIT_WAKEUP] = s_r.enable[`BIT_WAKEUP] & I_BUS_ACTIVITY & I_SLEEPING;
        set_vec[`BIT_OVERRUN] = s_r.enable[`BIT_OVERRUN] & ev_rise[`EV_OVR];
        set_vec[`BIT_STATUS_CHG] = s_r.enable[`BIT_STATUS_CHG] &
                                   (ev_rise[`EV_BUS] | ev_fall[`EV_BUS] |
                                    ev_rise[`EV_ERR] | ev_fall[`EV_ERR]);
        set_vec[`BIT_TX_DONE] = s_r.enable[`BIT_TX_DONE] & ev_rise[`EV_TXBUF];
        set_vec[`BIT_RX_PEND] = s_r.enable[`BIT_RX_PEND] & rx_nonempty;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus strobes

    assign wr_fire = (s_r.wr_state == WR_IDLE) && s_r.aw_held && s_r.w_held;
    assign wr_en = wr_fire && s_r.wr_lane;
    assign rd_take = I_ARVALID && s_r.arready;
    assign flags_read = rd_take && (I_ARADDR[6:2] == `IDX_FLAGS);
    assign release_now = wr_en && (s_r.wr_idx == `IDX_COMMAND) && s_r.wr_data[`BIT_RELEASE_RX];

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.release_pulse = 1'b0;
        s_nxt.clear_ovr_pulse = 1'b0;

        // write address and data are taken in either order
        if (I_AWVALID && s_r.awready)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.wr_idx = I_AWADDR[6:2];
        end
        if (I_WVALID && s_r.wready)
        begin
            s_nxt.w_held = 1'b1;
            s_nxt.wr_data = I_WDATA[7:0];
            s_nxt.wr_lane = I_WSTRB[0];
        end

        case (s_r.wr_state)
            WR_IDLE:
            begin
                if (wr_fire)
                begin
                    s_nxt.aw_held = 1'b0;
                    s_nxt.w_held = 1'b0;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.bresp = is_mapped(s_r.wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
                    s_nxt.wr_state = WR_RESP;
                end
            end
            WR_RESP:
            begin
                if (I_BREADY)
                begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wr_state = WR_IDLE;
                end
            end
            default:
                s_nxt.wr_state = WR_IDLE;
        endcase
        s_nxt.awready = !s_nxt.aw_held && (s_nxt.wr_state == WR_IDLE);
        s_nxt.wready = !s_nxt.w_held && (s_nxt.wr_state == WR_IDLE);

        // register writes, lane 0 only
        if (wr_en)
        begin
            if (s_r.wr_idx == `IDX_CONFIG)
                s_nxt.config_byte = s_r.wr_data & `CONFIG_MASK;
            else if (s_r.wr_idx == `IDX_COMMAND)
            begin
                s_nxt.release_pulse = s_r.wr_data[`BIT_RELEASE_RX];
                s_nxt.clear_ovr_pulse = s_r.wr_data[`BIT_CLEAR_OVR];
            end
            else if (s_r.wr_idx == `IDX_ENABLE)
                s_nxt.enable = s_r.wr_data;
            else if ((s_r.wr_idx == `IDX_WARN) && s_r.config_byte[`BIT_RESET_MODE])
                s_nxt.warn_limit = s_r.wr_data;
        end

        // staged limit goes live on the 1-to-0 edge of reset mode
        if (s_r.config_byte[`BIT_RESET_MODE] && !s_nxt.config_byte[`BIT_RESET_MODE])
            s_nxt.active_limit = s_r.warn_limit;

        case (s_r.rd_state)
            RD_IDLE:
            begin
                if (rd_take)
                begin
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rdata = rd_value(s_r, I_ARADDR[6:2], status_byte);
                    s_nxt.rresp = is_mapped(I_ARADDR[6:2]) ? `RESP_OKAY : `RESP_SLVERR;
                    s_nxt.rd_state = RD_RESP;
                end
            end
            RD_RESP:
            begin
                if (I_RREADY)
                begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rd_state = RD_IDLE;
                end
            end
            default:
                s_nxt.rd_state = RD_IDLE;
        endcase
        s_nxt.arready = (s_nxt.rd_state == RD_IDLE);

        // read clears flags 7..1, a same-cycle event still lands
        s_nxt.flags[7:1] = (flags_read ? 7'h00 : s_r.flags[7:1]) | set_vec[7:1];

        // hold receive flag off until the released message has left
        if (release_now && rx_last)
            s_nxt.rx_wait = 1'b1;
        else if (!rx_nonempty)
            s_nxt.rx_wait = 1'b0;
        s_nxt.flags[`BIT_RX_PEND] = set_vec[`BIT_RX_PEND] & !s_nxt.rx_wait;

        s_nxt.irq = |s_nxt.flags;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            s_r <= '0;
            s_r.config_byte <= `CONFIG_RESET;
            s_r.enable <= `ENABLE_RESET;
            s_r.warn_limit <= `WARN_RESET;
            s_r.active_limit <= `WARN_RESET;
        end
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign O_AWREADY = s_r.awready;
    assign O_WREADY = s_r.wready;
    assign O_BVALID = s_r.bvalid;
    assign O_BRESP = s_r.bresp;
    assign O_ARREADY = s_r.arready;
    assign O_RVALID = s_r.rvalid;
    assign O_RRESP = s_r.rresp;
    assign O_RDATA = {24'h000000, s_r.rdata};
    assign O_IRQ = s_r.irq;
    assign O_RESET_MODE = s_r.config_byte[`BIT_RESET_MODE];
    assign O_SLEEP_REQ = s_r.config_byte[`BIT_SLEEP_MODE];
    assign O_RELEASE_RX = s_r.release_pulse;
    assign O_CLEAR_OVERRUN = s_r.clear_ovr_pulse;
    assign O_WARN_LIMIT = s_r.active_limit;
    assign O_ERROR_STATUS = err_status;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    sequence warn_write_op;
        wr_en && (s_r.wr_idx == `IDX_WARN) && !s_r.config_byte[`BIT_RESET_MODE];
    endsequence

    sequence release_final;
        release_now && rx_last;
    endsequence

    a_warn_locked: assert property (warn_write_op |=> $stable(s_r.warn_limit))
        else $error("limit changed by write in operating mode");

    a_limit_applied: assert property ($fell(s_r.config_byte[`BIT_RESET_MODE]) |->
        (O_WARN_LIMIT == $past(s_r.warn_limit)))
        else $error("limit not applied on leaving reset mode");

    a_limit_frozen: assert property (!$fell(s_r.config_byte[`BIT_RESET_MODE]) |-> $stable(O_WARN_LIMIT))
        else $error("active limit moved outside reset exit");

    a_irq_level: assert property ((O_IRQ == (s_r.flags != 8'h00)))
        else $error("interrupt request does not match flags");

    a_read_clears: assert property (flags_read |=>
        ((s_r.flags[7:1] & ~$past(set_vec[7:1])) == 7'h00))
        else $error("flag read did not clear flags");

    a_bus_error: assert property ((I_BUS_ERROR && s_r.enable[`BIT_BUS_ERR]) |=> s_r.flags[`BIT_BUS_ERR])
        else $error("bus error flag not set");

    a_arb_gated: assert property ($rose(s_r.flags[`BIT_ARB_LOST]) |->
        $past(I_ARB_LOST && s_r.enable[`BIT_ARB_LOST]))
        else $error("arbitration flag without enabled event");

    a_overrun_edge: assert property ($rose(s_r.flags[`BIT_OVERRUN]) |-> $past(ev_rise[`EV_OVR]))
        else $error("overrun flag without rising status");

    a_tx_released: assert property ((ev_rise[`EV_TXBUF] && s_r.enable[`BIT_TX_DONE]) |=>
        s_r.flags[`BIT_TX_DONE])
        else $error("transmit flag not set");

    a_rx_release: assert property (release_final |=> (!s_r.flags[`BIT_RX_PEND] && O_RELEASE_RX))
        else $error("receive flag not cleared on release");

    a_wresp_hold: assert property ((O_BVALID && !I_BREADY) |=> (O_BVALID && $stable(O_BRESP)))
        else $error("write response dropped early");

endmodule : can_irq_ctrl

`default_nettype wire

/* File: verilog/can_irq_cfg.svh */
`ifndef CAN_IRQ_CFG_SVH
`define CAN_IRQ_CFG_SVH

// register indices, byte address is index times four
`define IDX_CONFIG 5'h00
`define IDX_COMMAND 5'h01
`define IDX_STATUS 5'h02
`define IDX_FLAGS 5'h03
`define IDX_ENABLE 5'h04
`define IDX_WARN 5'h0d

// reset values and configuration write mask
`define CONFIG_RESET 8'h01
`define ENABLE_RESET 8'h00
`define WARN_RESET 8'h60
`define CONFIG_MASK 8'h1f

// configuration and command bit positions
`define BIT_RESET_MODE 0
`define BIT_SLEEP_MODE 4
`define BIT_RELEASE_RX 2
`define BIT_CLEAR_OVR 3

// flag and enable bit positions
`define BIT_BUS_ERR 7
`define BIT_ARB_LOST 6
`define BIT_PASSIVE 5
`define BIT_WAKEUP 4
`define BIT_OVERRUN 3
`define BIT_STATUS_CHG 2
`define BIT_TX_DONE 1
`define BIT_RX_PEND 0

// status byte bit positions
`define STS_BUS 7
`define STS_ERR 6
`define STS_TXBUF 2
`define STS_OVR 1
`define STS_RXBUF 0

// edge tracker lanes
`define EV_OVR 0
`define EV_TXBUF 1
`define EV_OVER127 2
`define EV_PASSIVE 3
`define EV_BUS 4
`define EV_ERR 5
`define EV_WIDTH 6

`define PASSIVE_LEVEL 8'd127
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: verilog/can_irq_pkg.sv */
package can_irq_pkg;

    typedef enum logic {WR_IDLE, WR_RESP} wr_state_e;
    typedef enum logic {RD_IDLE, RD_RESP} rd_state_e;

    typedef struct packed {
        wr_state_e wr_state;
        logic aw_held;
        logic w_held;
        logic [4:0] wr_idx;
        logic [7:0] wr_data;
        logic wr_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        rd_state_e rd_state;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] config_byte;
        logic [7:0] enable;
        logic [7:0] flags;
        logic [7:0] warn_limit;
        logic [7:0] active_limit;
        logic irq;
        logic release_pulse;
        logic clear_ovr_pulse;
        logic rx_wait;
    } ctrl_state_s;

    typedef logic [7:0] byte_t;

endpackage : can_irq_pkg

/* File: verilog/can_edge_track.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_cfg.svh"

module can_edge_track #(
    parameter int W = `EV_WIDTH
) (
    input wire logic i_clk,           // core clock
    input wire logic i_resetn,        // async reset, active low
    input wire logic [W-1:0] i_level, // levels to watch
    output logic [W-1:0] o_rise,      // level went 0 to 1
    output logic [W-1:0] o_fall       // level went 1 to 0
);
    typedef struct packed {
        logic primed;
        logic [W-1:0] prev;
    } edge_state_s;

    edge_state_s s_r;
    edge_state_s s_nxt;

    // first cycle after reset only captures, no edges
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.primed = 1'b1;
        s_nxt.prev = i_level;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_rise = s_r.primed ? (i_level & ~s_r.prev) : '0;
    assign o_fall = s_r.primed ? (~i_level & s_r.prev) : '0;

endmodule : can_edge_track

`default_nettype wire

/* File: verilog/can_warn_check.sv */
`timescale 1ns/1ps
`default_nettype none

module can_warn_check #(
    parameter int CW = 8
) (
    input wire logic i_clk,             // core clock
    input wire logic i_resetn,          // async reset, active low
    input wire logic [CW-1:0] i_tx_cnt, // transmit error counter
    input wire logic [CW-1:0] i_rx_cnt, // receive error counter
    input wire logic [CW-1:0] i_limit,  // active warning limit
    output logic o_err_status           // error status, registered
);
    typedef struct packed {
        logic err;
    } warn_state_s;

    warn_state_s s_r;
    warn_state_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.err = (i_tx_cnt >= i_limit) || (i_rx_cnt >= i_limit);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign o_err_status = s_r.err;

    a_err_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ((i_tx_cnt >= i_limit) || (i_rx_cnt >= i_limit)) |=> o_err_status)
        else $error("error status not raised at limit");

endmodule : can_warn_check

`default_nettype wire

/* File: dv/can_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_core_model (
    input wire logic i_clk, // core clock
    input wire logic i_resetn, // reset, active low
    input wire logic i_add, // a message arrives
    input wire logic i_ovr, // a message is lost
    input wire logic i_release, // release receive buffer
    input wire logic i_clear, // clear overrun
    output logic [4:0] o_count, // messages held
    output logic o_overrun // overrun status
);
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_count <= 5'h00;
            o_overrun <= 1'b0;
        end
        else
        begin
            // one message leaves per release
            if (i_release && o_count != 5'h00)
                o_count <= o_count - 5'h01;
            else if (i_add)
                o_count <= o_count + 5'h01;
            if (i_clear)
                o_overrun <= 1'b0;
            else if (i_ovr)
                o_overrun <= 1'b1;
        end
    end
endmodule : can_core_model
`default_nettype wire

/* File: dv/can_interrupt_and_warning_limit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_cfg.svh"
module can_interrupt_and_warning_limit_tb_top;
    import can_irq_pkg::*;
    localparam logic [6:0] A_CFG = {`IDX_CONFIG, 2'b00};
    localparam logic [6:0] A_CMD = {`IDX_COMMAND, 2'b00};
    localparam logic [6:0] A_FLG = {`IDX_FLAGS, 2'b00};
    localparam logic [6:0] A_STS = {`IDX_STATUS, 2'b00};
    localparam logic [6:0] A_ENA = {`IDX_ENABLE, 2'b00};
    localparam logic [6:0] A_WRN = {`IDX_WARN, 2'b00};
    localparam logic [7:0] EXP_EV [3] = '{8'h80, 8'h40, 8'h10};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [6:0] awaddr = 7'h00;
    logic [6:0] araddr = 7'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0] pls = 5'h00;
    logic sleeping = 1'b0, passive = 1'b0, bus_off = 1'b0, tx_free = 1'b0;
    logic [7:0] tx_err = 8'h00, rx_err = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, irq, reset_mode, slp, rel, clr, err_st, ovr_st;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [4:0] cnt;
    byte_t wlim;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    can_irq_ctrl u_dut (
        .I_CLK(clk), .I_RESETN(rstn), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_BUS_ERROR(pls[0]),
        .I_ARB_LOST(pls[1]), .I_BUS_ACTIVITY(pls[2]), .I_SLEEPING(sleeping), .I_ERROR_PASSIVE(passive),
        .I_BUS_OFF(bus_off), .I_TX_BUF_FREE(tx_free), .I_DATA_OVERRUN(ovr_st), .I_RX_COUNT(cnt),
        .I_TX_ERR_CNT(tx_err), .I_RX_ERR_CNT(rx_err), .O_IRQ(irq), .O_RESET_MODE(reset_mode), .O_SLEEP_REQ(slp),
        .O_RELEASE_RX(rel), .O_CLEAR_OVERRUN(clr), .O_WARN_LIMIT(wlim), .O_ERROR_STATUS(err_st));

    can_core_model u_core (
        .i_clk(clk), .i_resetn(rstn), .i_add(pls[4]), .i_ovr(pls[3]), .i_release(rel),
        .i_clear(clr), .o_count(cnt), .o_overrun(ovr_st));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tick;
        repeat (4) @(posedge clk);
    endtask : tick

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clk);
            aw = aw || awready;
            w = w || wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        rs = bresp;
    endtask : wr

    task automatic rd_word(input logic [6:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rd_word

    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        rd_word(a);
        check(rd, {24'h0, e});
    endtask : rdchk

    task automatic pulse(input logic [4:0] p);
        pls <= p;
        @(posedge clk);
        pls <= 5'h00;
        repeat (3) @(posedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check(32'(wlim), 32'h60);
        check(32'(irq), 32'h0);
        rdchk(A_WRN, 8'h60);
        rdchk(A_ENA, 8'h00);
        wr(A_WRN, 8'h10);
        rdchk(A_WRN, 8'h10);
        check(32'(wlim), 32'h60);
        wr(A_CFG, 8'h00);
        check(32'(wlim), 32'h10);
        check(32'(reset_mode), 32'h0);
        wr(A_WRN, 8'h20);
        rdchk(A_WRN, 8'h10);
        wr(A_ENA, 8'hff);
        rdchk(A_ENA, 8'hff);
        sleeping <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            pulse(5'h01 << i);
            check(32'(irq), 32'h1);
            rdchk(A_FLG, EXP_EV[i]);
            rdchk(A_FLG, 8'h00);
        end
        tick();
        check(32'(irq), 32'h0);
        rx_err <= 8'h10;
        tick();
        check(32'(err_st), 32'h1);
        rdchk(A_FLG, 8'h04);
        tx_err <= 8'h80;
        tick();
        rdchk(A_FLG, 8'h20);
        bus_off <= 1'b1;
        tick();
        rdchk(A_FLG, 8'h04);
        passive <= 1'b1;
        tick();
        passive <= 1'b0;
        tick();
        rdchk(A_FLG, 8'h20);
        tx_free <= 1'b1;
        tick();
        rdchk(A_FLG, 8'h02);
        tx_free <= 1'b0;
        tick();
        rdchk(A_FLG, 8'h00);
        pulse(5'h08);
        rdchk(A_FLG, 8'h08);
        pulse(5'h08);
        rdchk(A_FLG, 8'h00);
        wr(A_CMD, 8'h08);
        pulse(5'h08);
        rdchk(A_FLG, 8'h08);
        wr(A_ENA, 8'h00);
        pulse(5'h01);
        rdchk(A_FLG, 8'h00);
        wr(A_ENA, 8'h01);
        pulse(5'h10);
        pulse(5'h10);
        rdchk(A_FLG, 8'h01);
        rdchk(A_FLG, 8'h01);
        wr(A_CMD, 8'h04);
        tick();
        rdchk(A_FLG, 8'h01);
        wr(A_CMD, 8'h04);
        tick();
        rdchk(A_FLG, 8'h00);
        check(32'(irq), 32'h0);
        rdchk(7'h7c, 8'h00);
        check(32'(rs), 32'(`RESP_SLVERR));
        rdchk(A_STS, 8'hc2);
        wr(A_CFG, 8'h10);
        check(32'(rs), 32'(`RESP_OKAY));
        check(32'(slp), 32'h1);
        check(32'(reset_mode), 32'h0);
        rdchk(A_CFG, 8'h10);
        print_verdict();
    end
endmodule : can_interrupt_and_warning_limit_tb_top
`default_nettype wire
